// File: clkout_and_ext_mem_pin_mux_tb_top.sv
// Self-checking testbench for the clock-out and memory pad selection block.
`define CHK(nm, e, g) \
	begin \
		checks++; \
		if ((g) !== (e)) \
		begin \
			$display("Error %s expected %h seen %h", nm, e, g); \
			mismatches++; \
		end \
	end

module clkout_and_ext_mem_pin_mux_tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	// One table row: the fields written and the pad decode they should give.
	typedef struct {
		logic        pci;
		logic [2:0]  mode;
		logic [2:0]  cs;
		logic        rmii;
		logic [21:0] addr;
		logic [15:0] data;
		logic [2:0]  mb;
		logic [2:0]  hi;
		logic [5:0]  gpio;
		logic        sup;
	} cpm_row_type;

	// ************************************************************
	// Signals
	// ************************************************************
	logic        i_core_clk;
	logic        i_reset;
	logic        w0_we;
	logic [2:0]  mode;
	logic [2:0]  cs;
	logic        rmii;
	logic        w1_we;
	logic        pci;
	logic [1:0]  ck_sel;
	logic        pw_we;
	logic        ck_pd;
	logic [3:0]  mem_pd;
	logic [1:0]  o_ck_fn;
	logic        o_ck_pd;
	logic [3:0]  o_mem_pd;
	logic [21:0] o_addr;
	logic [15:0] o_data;
	logic        o_rw;
	logic        o_cs2;
	logic        o_ba;
	logic [2:0]  o_hi;
	logic        o_ctl;
	logic        o_rm;
	logic        o_pci;
	logic [5:0]  o_gpio;
	logic        o_sup;
	int          mismatches;
	int          checks;
	cpm_row_type rows [20];

	cpm_pad_mux dut (
		.i_core_clk                 (i_core_clk),
		.i_reset                    (i_reset),
		.i_pin_select_word0_we      (w0_we),
		.i_async_pin_mode_field     (mode),
		.i_chip_select3_pad_enable  (cs[0]),
		.i_chip_select4_pad_enable  (cs[1]),
		.i_chip_select5_pad_enable  (cs[2]),
		.i_rmii_enable              (rmii),
		.i_pin_select_word1_we      (w1_we),
		.i_pci_pin_enable           (pci),
		.i_clock_out_pad_select     (ck_sel),
		.i_io_pad_power_down_ctl_we (pw_we),
		.i_clock_out_pad_power_down (ck_pd),
		.i_mem_pads_group_power_down(mem_pd),
		.o_clock_out_pad_fn         (o_ck_fn),
		.o_clock_out_pad_power_down (o_ck_pd),
		.o_mem_pads_group_power_down(o_mem_pd),
		.o_mem_address_bus_en       (o_addr),
		.o_mem_data_bus_en          (o_data),
		.o_mem_read_write_en        (o_rw),
		.o_mem_chip_select_two_en   (o_cs2),
		.o_mem_byte_address_en      (o_ba),
		.o_mem_chip_select_hi_en    (o_hi),
		.o_mem_control_pins_en      (o_ctl),
		.o_reduced_mii_pads_en      (o_rm),
		.o_pci_pads_en              (o_pci),
		.o_gpio_pad_count           (o_gpio),
		.o_config_supported         (o_sup)
	);

	// ************************************************************
	// Clock, verdict and watchdog
	// ************************************************************
	// A 4 ns period gives the 250 MHz core clock.
	initial i_core_clk = 1'h0;
	always #2 i_core_clk = ~i_core_clk;

	// Prints the counts and the verdict, then ends the run.
	task automatic test_done();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// The whole sequence needs well under 300 cycles, so 2000 means a hang.
	initial
	begin
		repeat (2000) @(posedge i_core_clk);
		mismatches++;
		test_done();
	end

	// ************************************************************
	// Tasks
	// ************************************************************
	// Writes both selection words; the strobes stay high so that back-to-back writes need no gap.
	task automatic set_cfg(input cpm_row_type r);
		pci   = r.pci;
		mode  = r.mode;
		cs    = r.cs;
		rmii  = r.rmii;
		w0_we = 1'h1;
		w1_we = 1'h1;
		@(negedge i_core_clk);
	endtask

	// Compares every memory pad enable and status output against a row; sub-group power is not compared.
	task automatic chk_row(input cpm_row_type r);
		`CHK("addr_en", r.addr, o_addr)
		`CHK("data_en", r.data, o_data)
		`CHK("rw_ba_cs2", r.mb, {o_rw, o_ba, o_cs2})
		`CHK("cs_hi", r.hi, o_hi)
		`CHK("gpio_count", r.gpio, o_gpio)
		`CHK("supported", r.sup, o_sup)
		`CHK("rmii_en", r.rmii, o_rm)
		`CHK("pci_en", r.pci, o_pci)
		`CHK("control_en", 1'h1, o_ctl)
	endtask

	// Checks the values every field takes at reset.
	task automatic chk_reset();
		`CHK("clk_fn", 2'h1, o_ck_fn)
		`CHK("clk_pd", 1'h0, o_ck_pd)
		`CHK("mem_pd", 4'h0, o_mem_pd)
		chk_row(rows[0]);
	endtask

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial
	begin
		// Columns: pci, mode, cs5..3, rmii, address, data, rw/ba/cs2, cs hi, gpio, ok.
		// PCI rows assume PCI is picked in every group it spans; MII is never enabled.
		rows = '{
			'{1'h0, 3'h0, 3'h0, 1'h0, 22'h0, 16'h0, 3'h0, 3'h0, 6'h3A, 1'h1},
			'{1'h0, 3'h0, 3'h0, 1'h1, 22'h0, 16'h0, 3'h0, 3'h0, 6'h32, 1'h1},
			'{1'h0, 3'h2, 3'h0, 1'h0, 22'h3FFFFF, 16'hFFFF, 3'h7, 3'h0, 6'h10, 1'h1},
			'{1'h0, 3'h2, 3'h7, 1'h0, 22'h3FFFFF, 16'hFFFF, 3'h7, 3'h7, 6'h0D, 1'h1},
			'{1'h0, 3'h2, 3'h5, 1'h0, 22'h3FFFFF, 16'hFFFF, 3'h7, 3'h5, 6'h0E, 1'h1},
			'{1'h0, 3'h2, 3'h1, 1'h1, 22'h3FFFFF, 16'hFFFF, 3'h7, 3'h1, 6'h07, 1'h1},
			'{1'h0, 3'h2, 3'h0, 1'h1, 22'h3FFFFF, 16'hFFFF, 3'h7, 3'h0, 6'h08, 1'h1},
			'{1'h0, 3'h2, 3'h2, 1'h1, 22'h3FFFFF, 16'hFFFF, 3'h7, 3'h0, 6'h08, 1'h0},
			'{1'h0, 3'h5, 3'h0, 1'h0, 22'h6, 16'hFF, 3'h1, 3'h0, 6'h2F, 1'h1},
			'{1'h0, 3'h5, 3'h7, 1'h0, 22'h6, 16'hFF, 3'h1, 3'h7, 6'h2C, 1'h1},
			'{1'h0, 3'h5, 3'h1, 1'h1, 22'h6, 16'hFF, 3'h1, 3'h1, 6'h26, 1'h1},
			'{1'h0, 3'h5, 3'h0, 1'h1, 22'h6, 16'hFF, 3'h1, 3'h0, 6'h27, 1'h1},
			'{1'h0, 3'h3, 3'h0, 1'h0, 22'h0, 16'h0, 3'h0, 3'h0, 6'h00, 1'h0},
			'{1'h0, 3'h7, 3'h0, 1'h0, 22'h0, 16'h0, 3'h0, 3'h0, 6'h00, 1'h0},
			'{1'h1, 3'h0, 3'h0, 1'h0, 22'h0, 16'h0, 3'h0, 3'h0, 6'h2A, 1'h1},
			'{1'h1, 3'h0, 3'h0, 1'h1, 22'h0, 16'h0, 3'h0, 3'h0, 6'h22, 1'h1},
			'{1'h1, 3'h5, 3'h7, 1'h0, 22'h6, 16'hFF, 3'h1, 3'h7, 6'h1C, 1'h1},
			'{1'h1, 3'h5, 3'h0, 1'h0, 22'h6, 16'hFF, 3'h1, 3'h0, 6'h1F, 1'h1},
			'{1'h1, 3'h5, 3'h1, 1'h1, 22'h6, 16'hFF, 3'h1, 3'h1, 6'h16, 1'h1},
			'{1'h1, 3'h2, 3'h0, 1'h0, 22'h0, 16'h0, 3'h0, 3'h0, 6'h00, 1'h0}
		};
		{w0_we, w1_we, pw_we, pci, rmii, ck_pd} = 6'h00;
		{mode, cs, mem_pd} = 10'h000;
		ck_sel = 2'h1;
		mismatches = 0;
		checks = 0;
		i_reset = 1'h1;
		repeat (10) @(negedge i_core_clk);
		i_reset = 1'h0;
		chk_reset();
		$display("test reset values done");

		// Every listed configuration, written back to back.
		foreach (rows[k])
		begin
			set_cfg(rows[k]);
			chk_row(rows[k]);
		end
		$display("test configuration table done");

		// Each clock-out code, the reserved one included, while word 0 holds the 16-bit setup.
		set_cfg(rows[3]);
		w0_we = 1'h0;
		for (int c = 0; c < 4; c++)
		begin
			ck_sel = c[1:0];
			@(negedge i_core_clk);
			`CHK("clk_fn", c[1:0], o_ck_fn)
			chk_row(rows[3]);
		end
		w1_we = 1'h0;
		$display("test clock-out select done");

		// Power fields walk one bit at a time and leave the routing alone.
		pw_we = 1'h1;
		for (int p = 0; p < 5; p++)
		begin
			{ck_pd, mem_pd} = 5'h01 << p;
			@(negedge i_core_clk);
			`CHK("clk_pd", ck_pd, o_ck_pd)
			`CHK("mem_pd", mem_pd, o_mem_pd)
			chk_row(rows[3]);
		end
		pw_we = 1'h0;
		$display("test power fields done");

		// Inputs without a write strobe must not reach the pads.
		{mode, cs, rmii, pci, ck_sel, ck_pd, mem_pd} = 15'h0000;
		repeat (2) @(negedge i_core_clk);
		chk_row(rows[3]);
		`CHK("clk_fn", 2'h3, o_ck_fn)
		`CHK("clk_pd", 1'h1, o_ck_pd)
		$display("test held fields done");

		// Two writes on consecutive edges; each must show at once.
		{pci, mode, cs, rmii} = {rows[10].pci, rows[10].mode, rows[10].cs, rows[10].rmii};
		{w0_we, w1_we} = 2'h3;
		@(negedge i_core_clk);
		chk_row(rows[10]);
		{pci, mode, cs, rmii} = {rows[2].pci, rows[2].mode, rows[2].cs, rows[2].rmii};
		@(negedge i_core_clk);
		{w0_we, w1_we} = 2'h0;
		chk_row(rows[2]);
		$display("test back to back writes done");

		// A reset in mid-run restores every default.
		i_reset = 1'h1;
		@(negedge i_core_clk);
		i_reset = 1'h0;
		chk_reset();
		$display("test second reset done");
		test_done();
	end
endmodule

// File: cpm_field_reg.sv
// One software-written selection field with its reset value.
module cpm_field_reg #(
	parameter int             WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET = '0
) (
	// Clock and reset.
	input  wire logic             i_core_clk,
	input  wire logic             i_reset,
	// Write port.
	input  wire logic             i_write,
	input  wire logic [WIDTH-1:0] i_data,
	// Stored value and the value it takes at the next edge.
	output logic      [WIDTH-1:0] o_value,
	output logic      [WIDTH-1:0] o_next
);

	logic [WIDTH-1:0] value_r;
	logic [WIDTH-1:0] value_nxt;

	// A write replaces the field; otherwise it holds.
	always_comb
	begin
		value_nxt = value_r;
		if (i_write)
		begin
			value_nxt = i_data;
		end
	end

	// Reset forces the field's default value.
	always_ff @(posedge i_core_clk)
	begin
		if (i_reset)
		begin
			value_r <= RESET;
		end
		else
		begin
			value_r <= value_nxt;
		end
	end

	// The next value lets the decode land on the same edge as the field.
	assign o_value = value_r;
	assign o_next  = i_reset ? RESET : value_nxt;

endmodule

// File: cpm_pad_mux.sv
// Pad function decode for the clock-out pad and the external-memory pad group.
module cpm_pad_mux (
	// Clock and reset.
	input  wire logic                              i_core_clk,
	input  wire logic                              i_reset,
	// Word 0 fields: async mode, chip-select enables, RMII enable.
	input  wire logic                              i_pin_select_word0_we,
	input  wire logic [2:0]                        i_async_pin_mode_field,
	input  wire logic                              i_chip_select3_pad_enable,
	input  wire logic                              i_chip_select4_pad_enable,
	input  wire logic                              i_chip_select5_pad_enable,
	input  wire logic                              i_rmii_enable,
	// Word 1 fields: PCI enable and clock-out select.
	input  wire logic                              i_pin_select_word1_we,
	input  wire logic                              i_pci_pin_enable,
	input  wire logic [1:0]                        i_clock_out_pad_select,
	// Pad power control fields.
	input  wire logic                              i_io_pad_power_down_ctl_we,
	input  wire logic                              i_clock_out_pad_power_down,
	input  wire logic [cpm_pkg::MEM_GROUPS-1:0]    i_mem_pads_group_power_down,
	// Clock-out pad.
	output logic      [1:0]                        o_clock_out_pad_fn,
	output logic                                   o_clock_out_pad_power_down,
	// Memory pad power per sub-group.
	output logic      [cpm_pkg::MEM_GROUPS-1:0]    o_mem_pads_group_power_down,
	// Memory port pad enables.
	output logic      [cpm_pkg::ADDR_PADS-1:0]     o_mem_address_bus_en,
	output logic      [cpm_pkg::DATA_PADS-1:0]     o_mem_data_bus_en,
	output logic                                   o_mem_read_write_en,
	output logic                                   o_mem_chip_select_two_en,
	output logic                                   o_mem_byte_address_en,
	output logic      [2:0]                        o_mem_chip_select_hi_en,
	output logic                                   o_mem_control_pins_en,
	// Other functions and status.
	output logic                                   o_reduced_mii_pads_en,
	output logic                                   o_pci_pads_en,
	output logic      [5:0]                        o_gpio_pad_count,
	output logic                                   o_config_supported
);

	// ************************************************************
	// Selection fields
	// ************************************************************
	logic [2:0] mode_q;
	logic [2:0] mode_n;
	logic [2:0] cs_q;
	logic [2:0] cs_n;
	logic       rmii_q;
	logic       rmii_n;
	logic       pci_q;
	logic       pci_n;
	logic [1:0] ckout_n;
	logic [4:0] pwr_n;

	cpm_field_reg #(.WIDTH(3), .RESET(cpm_pkg::MODE_RESET)) u_mode (
		.i_core_clk (i_core_clk),
		.i_reset    (i_reset),
		.i_write    (i_pin_select_word0_we),
		.i_data     (i_async_pin_mode_field),
		.o_value    (mode_q),
		.o_next     (mode_n)
	);

	cpm_field_reg #(.WIDTH(3), .RESET(3'h0)) u_cs (
		.i_core_clk (i_core_clk),
		.i_reset    (i_reset),
		.i_write    (i_pin_select_word0_we),
		.i_data     ({i_chip_select5_pad_enable, i_chip_select4_pad_enable,
		              i_chip_select3_pad_enable}),
		.o_value    (cs_q),
		.o_next     (cs_n)
	);

	cpm_field_reg #(.WIDTH(1), .RESET(cpm_pkg::FLAG_RESET)) u_rmii (
		.i_core_clk (i_core_clk),
		.i_reset    (i_reset),
		.i_write    (i_pin_select_word0_we),
		.i_data     (i_rmii_enable),
		.o_value    (rmii_q),
		.o_next     (rmii_n)
	);

	cpm_field_reg #(.WIDTH(1), .RESET(cpm_pkg::FLAG_RESET)) u_pci (
		.i_core_clk (i_core_clk),
		.i_reset    (i_reset),
		.i_write    (i_pin_select_word1_we),
		.i_data     (i_pci_pin_enable),
		.o_value    (pci_q),
		.o_next     (pci_n)
	);

	// Clock-out select resets to the device clock. [R2]
	cpm_field_reg #(.WIDTH(2), .RESET(cpm_pkg::CKOUT_SEL_RESET)) u_ckout (
		.i_core_clk (i_core_clk),
		.i_reset    (i_reset),
		.i_write    (i_pin_select_word1_we),
		.i_data     (i_clock_out_pad_select),
		.o_value    (),
		.o_next     (ckout_n)
	);

	// All five pad power fields reset to powered up. [R3] [R9]
	cpm_field_reg #(.WIDTH(5), .RESET({cpm_pkg::POWER_UP, cpm_pkg::MEM_POWER_RESET})) u_pwr (
		.i_core_clk (i_core_clk),
		.i_reset    (i_reset),
		.i_write    (i_io_pad_power_down_ctl_we),
		.i_data     ({i_clock_out_pad_power_down, i_mem_pads_group_power_down}),
		.o_value    (),
		.o_next     (pwr_n)
	);

	// ************************************************************
	// Decode
	// ************************************************************
	cpm_pkg::cpm_mem_mode_type      mem_mode;
	logic [cpm_pkg::ADDR_PADS-1:0]  addr_nxt;
	logic [cpm_pkg::DATA_PADS-1:0]  data_nxt;
	logic                           rw_nxt;
	logic                           cs2_nxt;
	logic [2:0]                     cshi_nxt;
	logic [5:0]                     gpio_nxt;
	logic [5:0]                     cs_free;
	logic                           ok_nxt;

	// Decode from the fields' next values so the pads follow a write on the same edge. [R17]
	// Only the memory group fields feed this process. [R4]
	always_comb
	begin
		mem_mode = cpm_pkg::MEM_MODE_OTHER;
		addr_nxt = '0;
		data_nxt = '0;
		rw_nxt   = 1'b0;
		cs2_nxt  = 1'b0;
		cshi_nxt = 3'h0;
		gpio_nxt = 6'h0;
		ok_nxt   = 1'b1;
		case (mode_n)
			cpm_pkg::MODE_CODE_GPIO:  mem_mode = cpm_pkg::MEM_MODE_GPIO;
			cpm_pkg::MODE_CODE_ASYNC: mem_mode = cpm_pkg::MEM_MODE_ASYNC16;
			cpm_pkg::MODE_CODE_NAND:  mem_mode = cpm_pkg::MEM_MODE_NAND8;
			default:                  mem_mode = cpm_pkg::MEM_MODE_OTHER;
		endcase
		// With RMII on, only chip select 3 may leave GPIO. [R13] [R15]
		cshi_nxt = rmii_n ? {2'b00, cs_n[0]} : cs_n;
		// Each chip-select pad not claimed stays a GPIO line. [R12] [R14]
		cs_free  = rmii_n ? {5'h0, ~cs_n[0]}
		                  : 6'({5'h0, ~cs_n[0]} + {5'h0, ~cs_n[1]} + {5'h0, ~cs_n[2]});
		case (mem_mode)
			cpm_pkg::MEM_MODE_GPIO:
			begin
				cshi_nxt = 3'h0;
				gpio_nxt = pci_n ? (rmii_n ? cpm_pkg::GPIO_PCI_RMII : cpm_pkg::GPIO_PCI)
				                 : (rmii_n ? cpm_pkg::GPIO_RMII : cpm_pkg::GPIO_ALL); // [R10] [R11]
				ok_nxt   = (cs_n == 3'h0);
			end
			cpm_pkg::MEM_MODE_ASYNC16:
			begin
				// Full 16-bit pinout; sub-group 3 carries address bits 12 to 6. [R12] [R8]
				addr_nxt = '1;
				data_nxt = '1;
				rw_nxt   = 1'b1;
				cs2_nxt  = 1'b1;
				gpio_nxt = 6'((rmii_n ? cpm_pkg::GPIO_ASYNC_RMII : cpm_pkg::GPIO_ASYNC) + cs_free);
				// PCI takes sub-group 3 and the upper address pads, which this pinout needs.
				ok_nxt   = !pci_n && !(rmii_n && (cs_n[2:1] != 2'h0));
				if (pci_n)
				begin
					addr_nxt = '0;
					data_nxt = '0;
					rw_nxt   = 1'b0;
					cs2_nxt  = 1'b0;
					cshi_nxt = 3'h0;
					gpio_nxt = 6'h0;
				end
			end
			cpm_pkg::MEM_MODE_NAND8:
			begin
				// Eight data bits and address bits 2 and 1. [R14]
				addr_nxt = 22'h000006;
				data_nxt = 16'h00FF;
				cs2_nxt  = 1'b1;
				gpio_nxt = 6'((pci_n ? (rmii_n ? cpm_pkg::GPIO_PCI_NAND_RM : cpm_pkg::GPIO_PCI_NAND)
				                     : (rmii_n ? cpm_pkg::GPIO_NAND_RMII : cpm_pkg::GPIO_NAND))
				              + cs_free); // [R14] [R15]
				ok_nxt   = !(rmii_n && (cs_n[2:1] != 2'h0));
			end
			default:
			begin
				// Unsupported mode code: no memory or GPIO pads are claimed; the RMII and PCI enables still follow their fields.
				cshi_nxt = 3'h0;
				ok_nxt   = 1'b0;
			end
		endcase
	end

	// ************************************************************
	// Output registers
	// ************************************************************
	always_ff @(posedge i_core_clk)
	begin
		o_clock_out_pad_fn          <= ckout_n; // [R1]
		o_clock_out_pad_power_down  <= pwr_n[4]; // [R3]
		o_mem_pads_group_power_down <= pwr_n[3:0]; // [R9]
		o_mem_address_bus_en        <= addr_nxt;
		o_mem_data_bus_en           <= data_nxt;
		o_mem_read_write_en         <= rw_nxt;
		o_mem_chip_select_two_en    <= cs2_nxt;
		o_mem_byte_address_en       <= rw_nxt;
		o_mem_chip_select_hi_en     <= cshi_nxt;
		o_mem_control_pins_en       <= 1'b1; // [R7]
		o_reduced_mii_pads_en       <= rmii_n; // [R11] [R13]
		o_pci_pads_en               <= pci_n; // [R8]
		o_gpio_pad_count            <= gpio_nxt;
		o_config_supported          <= ok_nxt;
	end

	// ************************************************************
	// Checks
	// ************************************************************
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (i_reset);

	sequence s_word0_write;
		i_pin_select_word0_we ##1 1'b1;
	endsequence

	a_clkout_reset_value: assert property (disable iff (1'b0) // [R2]
		i_reset |=> o_clock_out_pad_fn == cpm_pkg::CKOUT_SEL_DEVCLK)
		else $error("clock-out pad not on device clock after reset");
	a_clkout_route_follow: assert property ( // [R1]
		i_pin_select_word1_we |=> o_clock_out_pad_fn == $past(i_clock_out_pad_select))
		else $error("clock-out pad does not follow its select field");
	a_power_reset_up: assert property (disable iff (1'b0) // [R9]
		i_reset |=> (o_mem_pads_group_power_down == 4'h0) && !o_clock_out_pad_power_down)
		else $error("pads not powered up after reset");
	a_control_pins_fixed: assert property (o_mem_control_pins_en) // [R7]
		else $error("memory control pins lost their function");
	a_gpio_only_count: assert property ( // [R10]
		(mode_q == 3'h0 && !pci_q && !rmii_q) |->
		(o_gpio_pad_count == 6'h3A) && (o_mem_address_bus_en == '0) && !o_reduced_mii_pads_en)
		else $error("all-GPIO configuration decoded wrongly");
	a_rmii_only_count: assert property ( // [R11]
		(mode_q == 3'h0 && !pci_q && rmii_q) |-> o_reduced_mii_pads_en && o_gpio_pad_count == 6'h32)
		else $error("RMII-only configuration decoded wrongly");
	a_async16_pinout: assert property ( // [R12]
		(mode_q == 3'h2 && !pci_q && !rmii_q) |->
		(o_mem_address_bus_en == '1) && (o_mem_data_bus_en == '1) && o_mem_chip_select_two_en
		&& (o_mem_chip_select_hi_en == cs_q))
		else $error("16-bit async pinout decoded wrongly");
	a_async16_rmii_cs: assert property ( // [R13]
		(mode_q == 3'h2 && !pci_q && rmii_q) |->
		o_reduced_mii_pads_en && (o_mem_chip_select_hi_en[2:1] == 2'h0))
		else $error("chip selects 4 or 5 claimed with RMII on");
	a_nand8_pinout: assert property ( // [R14]
		(mode_q == 3'h5 && !pci_q && !rmii_q && cs_q == 3'h7) |->
		(o_mem_data_bus_en == 16'h00FF) && (o_mem_address_bus_en == 22'h000006)
		&& (o_gpio_pad_count == 6'h2C))
		else $error("NAND pinout decoded wrongly");
	a_nand8_rmii_gpio: assert property ( // [R15]
		(mode_q == 3'h5 && !pci_q && rmii_q && cs_q[0]) |-> o_gpio_pad_count == 6'h26)
		else $error("NAND with RMII gives wrong GPIO count");
	a_subgroup3_address: assert property ( // [R8]
		(o_mem_address_bus_en[cpm_pkg::SUBGRP3_MSB:cpm_pkg::SUBGRP3_LSB] != 7'h00)
		|-> (mode_q == cpm_pkg::MODE_CODE_ASYNC) && !pci_q)
		else $error("sub-group 3 carries address outside 16-bit mode");
	a_write_same_edge: assert property ( // [R17]
		s_word0_write |-> o_reduced_mii_pads_en == $past(i_rmii_enable))
		else $error("pad routing lags a field write");

endmodule

// File: cpm_pkg.sv
// Constants and types for the clock-out and external-memory pad selection block.
//
// Operation
// R1 - The clock-out select field routes the shared pad to GPIO (00), device clock (01) or pulse-width output two (10); 11 is reserved.
// R2 - After reset the clock-out select field routes the device clock output to the shared pad.
// R3 - A power-down field controls the clock-out pad and resets to powered up.
// R4 - The memory pad group is decoded only from async pin mode, the three chip-select enables, RMII enable and PCI enable.
// R5 - Software wanting PCI must select PCI in every pad group that PCI pins occupy.
// R6 - Software must never enable both the MII and the RMII pad sets.
// R7 - The wait/ready, output-enable and write-enable pads are always memory control pins.
// R8 - Sub-group 3 carries memory address bits 12 to 6, PCI or GPIO, chosen by async mode and PCI enable.
// R9 - Four power-down fields, one per memory pad sub-group, reset to powered up.
// R10 - With PCI 0, mode 000 and RMII 0 all 58 multiplexed pads are GPIO.
// R11 - With PCI 0, mode 000 and RMII 1 the RMII pins appear and 50 pads are GPIO.
// R12 - With PCI 0, mode 010 and RMII 0 the 16-bit async pinout appears, chip selects 3 to 5 optional.
// R13 - With PCI 0, mode 010 and RMII 1 both the 16-bit pinout and RMII appear, only chip select 3 optional.
// R14 - With PCI 0, mode 101 and RMII 0 the 8-bit NAND pinout appears with 44 base GPIO pads.
// R15 - With PCI 0, mode 101 and RMII 1 NAND and RMII appear with 38 base GPIO pads.
// R16 - Software programs only the listed major configurations; others have undefined routing.
// R17 - Pad routing follows the selection fields directly, with no sequencing or handshake.
package cpm_pkg;

	// ************************************************************
	// Clock-out pad select codes
	// ************************************************************
	localparam logic [1:0] CKOUT_SEL_GPIO   = 2'h0;
	localparam logic [1:0] CKOUT_SEL_DEVCLK = 2'h1;
	localparam logic [1:0] CKOUT_SEL_PULSE2 = 2'h2;
	localparam logic [1:0] CKOUT_SEL_RESV   = 2'h3;

	// ************************************************************
	// Async pin mode codes
	// ************************************************************
	localparam logic [2:0] MODE_CODE_GPIO   = 3'h0;
	localparam logic [2:0] MODE_CODE_ASYNC  = 3'h2;
	localparam logic [2:0] MODE_CODE_NAND   = 3'h5;

	// ************************************************************
	// Values after reset
	// ************************************************************
	localparam logic [1:0] CKOUT_SEL_RESET  = CKOUT_SEL_DEVCLK;
	localparam logic       POWER_UP         = 1'h0;
	localparam logic [3:0] MEM_POWER_RESET  = 4'h0;
	localparam logic [2:0] MODE_RESET       = MODE_CODE_GPIO;
	localparam logic       FLAG_RESET       = 1'h0;

	// ************************************************************
	// Pad counts and field widths
	// ************************************************************
	localparam int         ADDR_PADS        = 22;
	localparam int         DATA_PADS        = 16;
	localparam int         MEM_GROUPS       = 4;
	localparam int         SUBGRP3_LSB      = 6;
	localparam int         SUBGRP3_MSB      = 12;
	localparam logic [5:0] GPIO_ALL         = 6'h3A;
	localparam logic [5:0] GPIO_RMII        = 6'h32;
	localparam logic [5:0] GPIO_ASYNC       = 6'h0D;
	localparam logic [5:0] GPIO_ASYNC_RMII  = 6'h07;
	localparam logic [5:0] GPIO_NAND        = 6'h2C;
	localparam logic [5:0] GPIO_NAND_RMII   = 6'h26;
	localparam logic [5:0] GPIO_PCI         = 6'h2A;
	localparam logic [5:0] GPIO_PCI_RMII    = 6'h22;
	localparam logic [5:0] GPIO_PCI_NAND    = 6'h1C;
	localparam logic [5:0] GPIO_PCI_NAND_RM = 6'h16;

	// Decoded memory pad mode.
	typedef enum logic [1:0] {
		MEM_MODE_GPIO,
		MEM_MODE_ASYNC16,
		MEM_MODE_NAND8,
		MEM_MODE_OTHER
	} cpm_mem_mode_type;

endpackage
